// [pdt_pkg.sv]
// pdt_pkg: constants, register map, enumerations and state layouts of the prescaled down counter timer
// assumes a single clk_sys domain at 20 MHz and an APB slave port with 8-bit byte addresses
package pdt_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // widths
  localparam int PDT_ADDR_W = 8;
  localparam int PDT_DATA_W = 32;
  localparam int PDT_CNT_W = 8;
  localparam int PDT_PRE_W = 7;
  localparam int PDT_SEL_W = 3;
  localparam int PDT_EVT_W = 2;

  ////////////////////////////////////////////////////////////////////////////////
  // register indices; byte address is four times the index
  localparam logic [7:0] PDT_IDX_TDR = 8'h08;
  localparam logic [7:0] PDT_IDX_TCR = 8'h09;
  localparam logic [7:0] PDT_IDX_EVT = 8'h0A;
  localparam logic [7:0] PDT_IDX_EMSK = 8'h0B;
  localparam logic [7:0] PDT_ADDR_TDR = 8'(PDT_IDX_TDR * 4);
  localparam logic [7:0] PDT_ADDR_TCR = 8'(PDT_IDX_TCR * 4);
  localparam logic [7:0] PDT_ADDR_EVT = 8'(PDT_IDX_EVT * 4);
  localparam logic [7:0] PDT_ADDR_EMSK = 8'(PDT_IDX_EMSK * 4);

  ////////////////////////////////////////////////////////////////////////////////
  // timer_control field positions
  localparam int PDT_TCR_FLAG = 7;
  localparam int PDT_TCR_BLOCK = 6;
  localparam int PDT_TCR_SRC = 5;
  localparam int PDT_TCR_PIN = 4;
  localparam int PDT_TCR_CLR = 3;
  localparam int PDT_TCR_SEL_HI = 2;
  localparam int PDT_TCR_SEL_LO = 0;

  // event status / mask bit positions
  localparam int PDT_EVT_ZERO = 0;
  localparam int PDT_EVT_WRAP = 1;

  ////////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic PDT_FLAG_RST = 1'b0;
  localparam logic PDT_BLOCK_RST = 1'b1;
  localparam logic PDT_SRC_RST = 1'b0;
  localparam logic PDT_PIN_RST = 1'b0;
  localparam logic [PDT_SEL_W-1:0] PDT_SEL_RST = 3'h0;
  localparam logic [PDT_EVT_W-1:0] PDT_EVT_RST = 2'h0;
  localparam logic [PDT_EVT_W-1:0] PDT_EMSK_RST = 2'h0;
  localparam logic [PDT_PRE_W-1:0] PDT_PRE_RST = 7'h00;

  ////////////////////////////////////////////////////////////////////////////////
  // timing: phase-two clock is the system clock divided by four
  localparam int PDT_CLK_HZ = 20_000_000;
  localparam int PDT_P2_DIV = 4;
  localparam logic [1:0] PDT_P2_LAST = 2'(PDT_P2_DIV - 1);

  ////////////////////////////////////////////////////////////////////////////////
  // enumerations
  typedef enum logic [1:0] {
    PDT_APB_IDLE = 2'b00,
    PDT_APB_DONE = 2'b01
  } pdt_apb_e;

  // index is {source_select, pin_input_enable}
  typedef enum logic [1:0] {
    PDT_MODE_INT = 2'b00,
    PDT_MODE_GATED = 2'b01,
    PDT_MODE_OFF = 2'b10,
    PDT_MODE_EXT = 2'b11
  } pdt_mode_e;

  typedef enum logic [2:0] {
    PDT_REG_NONE = 3'h0,
    PDT_REG_TDR = 3'h1,
    PDT_REG_TCR = 3'h2,
    PDT_REG_EVT = 3'h3,
    PDT_REG_EMSK = 3'h4
  } pdt_reg_e;

  ////////////////////////////////////////////////////////////////////////////////
  // state layouts
  typedef struct packed {
    logic [PDT_PRE_W-1:0] cnt;
  } pdt_pre_s;

  typedef struct packed {
    pdt_apb_e apb;
    logic pready;
    logic pslverr;
    logic [PDT_DATA_W-1:0] prdata;
    logic flag;
    logic block;
    logic src;
    logic pin_en;
    logic [PDT_SEL_W-1:0] sel;
    logic [PDT_CNT_W-1:0] count;
    logic [PDT_EVT_W-1:0] evt;
    logic [PDT_EVT_W-1:0] emsk;
    logic [1:0] p2_div;
    logic pin_prev;
    logic timer_irq;
    logic evt_irq;
  } pdt_state_s;

  // reset image; the count field is carried through untouched
  function automatic pdt_state_s pdt_reset_state(input logic [PDT_CNT_W-1:0] keep_count);
    pdt_state_s s;
    s = '0;
    s.apb = PDT_APB_IDLE;
    s.flag = PDT_FLAG_RST;
    s.block = PDT_BLOCK_RST;
    s.src = PDT_SRC_RST;
    s.pin_en = PDT_PIN_RST;
    s.sel = PDT_SEL_RST;
    s.evt = PDT_EVT_RST;
    s.emsk = PDT_EMSK_RST;
    s.count = keep_count;
    return s;
  endfunction : pdt_reset_state

endpackage : pdt_pkg

// [pdt_pre_if.sv]
// pdt_pre_if: signals between the timer core and its prescaler
// assumes both ends run on clk_sys
`timescale 1ns/1ps
`default_nettype none
interface pdt_pre_if;
  logic src_tick;
  logic clear;
  logic [2:0] sel;
  logic div_tick;
  modport ctrl (output src_tick, output clear, output sel, input div_tick);
  modport pre (input src_tick, input clear, input sel, output div_tick);
endinterface : pdt_pre_if
`default_nettype wire

// [pdt_prescaler.sv]
// pdt_prescaler: 7-bit prescaler with eight selectable power-of-two taps
// assumes src_tick is a one-cycle pulse per rising edge of the chosen source
`timescale 1ns/1ps
`default_nettype none
module pdt_prescaler (
  input wire logic clk_sys,
  input wire logic srst,
  pdt_pre_if.pre pif
);
  import pdt_pkg::*;

  pdt_pre_s pre_reg;
  pdt_pre_s pre_next;
  logic [PDT_PRE_W-1:0] tap_mask;

  ////////////////////////////////////////////////////////////////////////////////
  // low bits that must all be ones for the selected ratio
  genvar gi;
  generate
    for (gi = 0; gi < PDT_PRE_W; gi++) begin : g_tap
      assign tap_mask[gi] = (gi < int'(pif.sel));
    end
  endgenerate

  // ratio is two to the power of sel; sel zero passes every source edge
  assign pif.div_tick = pif.src_tick & ~pif.clear & (&(pre_reg.cnt | ~tap_mask));

  always_comb begin
    pre_next = pre_reg;
    if (pif.clear) begin
      pre_next.cnt = PDT_PRE_RST;
    end else if (pif.src_tick) begin
      pre_next.cnt = pre_reg.cnt + 7'h01;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      pre_reg.cnt <= PDT_PRE_RST;
    end else begin
      pre_reg <= pre_next;
    end
  end

endmodule : pdt_prescaler
`default_nettype wire

// [pdt_timer.sv]
// pdt_timer: prescaled 8-bit down counter timer with APB register access
// assumes APB master on clk_sys; timer_pin and cpu_int_mask are synchronous to clk_sys
//
// What this block does
// - 8-bit loadable counter, clocked by 7-bit prescaler output, counts down.
// - counter reaching zero sets the request flag, timer_control bit 7.
// - request set only on the step from one to zero.
// - bit 6 blocks the interrupt; core sees it only with global mask clear.
// - flag cleared by reset or by writing zero to it.
// - writing one to bit 3 clears the prescaler; bit 3 reads zero.
// - counter wraps from zero to all ones and keeps counting.
// - counter readable any time without disturbing the count.
// - reset leaves the counter value unchanged.
// - bits 5,4 = 00: internal clock, pin ignored, runs during wait.
// - bits 5,4 = 01: internal clock gated by the pin being high.
// - bits 5,4 = 10: no prescaler input, timer stopped.
// - bits 5,4 = 11: prescaler counts rising edges of the pin.
// - internal clock is the system clock divided by four.
// - bits 2..0 select divide ratio two to the field value.
// - prescaler and counter advance on rising edge of the source.
// - a write loads the counter, which then counts down from it.
//
// Added by the designer: register access over APB.
`timescale 1ns/1ps
`default_nettype none
module pdt_timer (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [pdt_pkg::PDT_ADDR_W-1:0] paddr,
  input wire logic [pdt_pkg::PDT_DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [pdt_pkg::PDT_DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic timer_pin,
  input wire logic cpu_int_mask,
  output logic timer_irq,
  output logic evt_irq
);
  import pdt_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // decode

  function automatic pdt_reg_e pdt_decode(input logic [PDT_ADDR_W-1:0] addr);
    pdt_reg_e r;
    case (addr)
      PDT_ADDR_TDR: r = PDT_REG_TDR;
      PDT_ADDR_TCR: r = PDT_REG_TCR;
      PDT_ADDR_EVT: r = PDT_REG_EVT;
      PDT_ADDR_EMSK: r = PDT_REG_EMSK;
      default: r = PDT_REG_NONE;
    endcase
    return r;
  endfunction : pdt_decode

  function automatic logic [PDT_DATA_W-1:0] pdt_widen(input logic [7:0] v);
    return {24'h000000, v};
  endfunction : pdt_widen

  ////////////////////////////////////////////////////////////////////////////////
  // state

  pdt_state_s state_reg;
  pdt_state_s state_next;

  pdt_pre_if pif ();

  pdt_prescaler u_prescaler (
    .clk_sys(clk_sys),
    .srst(srst),
    .pif(pif)
  );

  pdt_reg_e acc_reg_sel;
  logic acc_done;
  logic wr_done;
  logic rd_done;
  logic lane0;
  logic p2_tick;
  logic pin_rise;
  pdt_mode_e mode;
  logic wr_tcr;
  logic wr_tdr;
  logic wr_evt_mask;
  logic rd_evt;
  logic zero_hit;
  logic wrap_hit;
  logic [PDT_EVT_W-1:0] evt_set;
  logic [PDT_EVT_W-1:0] evt_clr;
  logic [7:0] tcr_view;

  ////////////////////////////////////////////////////////////////////////////////
  // bus qualification

  assign acc_reg_sel = pdt_decode(paddr);
  // transfer completes on the edge where pready stands high in the access phase
  assign acc_done = psel & penable & state_reg.pready;
  assign wr_done = acc_done & pwrite;
  assign rd_done = acc_done & ~pwrite;
  assign lane0 = pstrb[0];
  assign wr_tcr = wr_done & lane0 & (acc_reg_sel == PDT_REG_TCR);
  assign wr_tdr = wr_done & lane0 & (acc_reg_sel == PDT_REG_TDR);
  assign wr_evt_mask = wr_done & lane0 & (acc_reg_sel == PDT_REG_EMSK);
  assign rd_evt = rd_done & (acc_reg_sel == PDT_REG_EVT);

  ////////////////////////////////////////////////////////////////////////////////
  // clock source selection

  // one pulse every fourth system clock stands for the phase-two rising edge
  assign p2_tick = (state_reg.p2_div == PDT_P2_LAST);
  assign pin_rise = timer_pin & ~state_reg.pin_prev;
  assign mode = pdt_mode_e'({state_reg.src, state_reg.pin_en});

  always_comb begin
    case (mode)
      PDT_MODE_INT: pif.src_tick = p2_tick;
      PDT_MODE_GATED: pif.src_tick = p2_tick & timer_pin;
      PDT_MODE_OFF: pif.src_tick = 1'b0;
      PDT_MODE_EXT: pif.src_tick = pin_rise;
      default: pif.src_tick = 1'b0;
    endcase
  end

  // write of one to the clear bit resets the prescaler on that edge
  assign pif.clear = wr_tcr & pwdata[PDT_TCR_CLR];
  assign pif.sel = state_reg.sel;

  ////////////////////////////////////////////////////////////////////////////////
  // counter events

  // a load in the same cycle takes precedence over the step
  assign zero_hit = pif.div_tick & ~wr_tdr & (state_reg.count == 8'h01);
  assign wrap_hit = pif.div_tick & ~wr_tdr & (state_reg.count == 8'h00);

  always_comb begin
    evt_set = '0;
    evt_set[PDT_EVT_ZERO] = zero_hit;
    evt_set[PDT_EVT_WRAP] = wrap_hit;
  end

  // reading the event register clears the bits it holds while pready is high, one edge after prdata sampled them
  assign evt_clr = rd_evt ? state_reg.evt : '0;

  // clear bit always reads back as zero
  assign tcr_view = {state_reg.flag, state_reg.block, state_reg.src, state_reg.pin_en,
                     1'b0, state_reg.sel};

  ////////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    state_next = state_reg;

    // phase-two divider and pin edge history
    state_next.p2_div = state_reg.p2_div + 2'h1;
    state_next.pin_prev = timer_pin;

    // counter: load wins over a step; count keeps running through core wait
    if (wr_tdr) begin
      state_next.count = pwdata[PDT_CNT_W-1:0];
    end else if (pif.div_tick) begin
      state_next.count = state_reg.count - 8'h01;
    end

    // request flag: hardware set wins over a software write of zero
    if (zero_hit) begin
      state_next.flag = 1'b1;
    end else if (wr_tcr & ~pwdata[PDT_TCR_FLAG]) begin
      state_next.flag = 1'b0;
    end

    // control fields
    if (wr_tcr) begin
      state_next.block = pwdata[PDT_TCR_BLOCK];
      state_next.src = pwdata[PDT_TCR_SRC];
      state_next.pin_en = pwdata[PDT_TCR_PIN];
      state_next.sel = pwdata[PDT_TCR_SEL_HI:PDT_TCR_SEL_LO];
    end

    // sticky events, read to clear, set wins
    state_next.evt = (state_reg.evt & ~evt_clr) | evt_set;
    if (wr_evt_mask) begin
      state_next.emsk = pwdata[PDT_EVT_W-1:0];
    end

    // bus answer: one wait state, then pready for one cycle
    case (state_reg.apb)
      PDT_APB_IDLE: begin
        state_next.pready = 1'b0;
        state_next.pslverr = 1'b0;
        if (psel & penable) begin
          state_next.apb = PDT_APB_DONE;
          state_next.pready = 1'b1;
          state_next.pslverr = (acc_reg_sel == PDT_REG_NONE);
          state_next.prdata = '0;
          if (~pwrite) begin
            case (acc_reg_sel)
              PDT_REG_TDR: state_next.prdata = pdt_widen(state_reg.count);
              PDT_REG_TCR: state_next.prdata = pdt_widen(tcr_view);
              PDT_REG_EVT: state_next.prdata = pdt_widen({6'h00, state_reg.evt});
              PDT_REG_EMSK: state_next.prdata = pdt_widen({6'h00, state_reg.emsk});
              default: state_next.prdata = '0;
            endcase
          end
        end
      end
      PDT_APB_DONE: begin
        state_next.apb = PDT_APB_IDLE;
        state_next.pready = 1'b0;
        state_next.pslverr = 1'b0;
        // read data stands only with pready
        state_next.prdata = '0;
      end
      default: begin
        state_next.apb = PDT_APB_IDLE;
        state_next.pready = 1'b0;
        state_next.pslverr = 1'b0;
        state_next.prdata = '0;
      end
    endcase

    // interrupt outputs follow the new flag and masks in the same edge
    state_next.timer_irq = state_next.flag & ~state_next.block & ~cpu_int_mask;
    state_next.evt_irq = |(state_next.evt & state_next.emsk);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_reg <= pdt_reset_state(state_reg.count);
    end else begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs

  assign prdata = state_reg.prdata;
  assign pready = state_reg.pready;
  assign pslverr = state_reg.pslverr;
  assign timer_irq = state_reg.timer_irq;
  assign evt_irq = state_reg.evt_irq;

endmodule : pdt_timer
`default_nettype wire

// [pdt_timer_properties.sv]
// pdt_timer_properties: apb and interrupt timing checks for pdt_timer
// assumes it is bound onto pdt_timer, one clk_sys domain
`timescale 1ns/1ps
`default_nettype none
module pdt_timer_properties (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [pdt_pkg::PDT_ADDR_W-1:0] paddr,
  input wire logic [pdt_pkg::PDT_DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [pdt_pkg::PDT_DATA_W-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic timer_pin,
  input wire logic cpu_int_mask,
  input wire logic timer_irq,
  input wire logic evt_irq
);
  import pdt_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  logic mapped;
  assign mapped = paddr inside {PDT_ADDR_TDR, PDT_ADDR_TCR, PDT_ADDR_EVT, PDT_ADDR_EMSK};
  ////////////////////////////////////////
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable;
  endsequence
  a_ready_timing: assert property (s_setup ##1 s_access |-> !pready ##1 pready ##1 !pready) else $error("pready timing");
  a_ready_needs_req: assert property (pready |-> $past(psel && penable)) else $error("pready without request");
  a_rdata_idle: assert property (!pready |-> prdata == '0) else $error("prdata not zero");
  a_err_unmapped: assert property (pready && !mapped |-> pslverr && prdata == '0) else $error("no error");
  a_err_mapped: assert property (pready && mapped |-> !pslverr) else $error("spurious error");
  a_clear_bit_zero: assert property (pready && !pwrite && paddr == PDT_ADDR_TCR |-> prdata[3] == 1'b0) else $error("bit 3 read one");
  a_irq_core_mask: assert property (timer_irq |-> !$past(cpu_int_mask)) else $error("irq while masked");
  a_reset_quiet: assert property ($past(srst) |-> !pready && !timer_irq && !evt_irq) else $error("outputs after reset");
endmodule : pdt_timer_properties
bind pdt_timer pdt_timer_properties u_props (.clk_sys(clk_sys), .srst(srst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .timer_pin(timer_pin), .cpu_int_mask(cpu_int_mask), .timer_irq(timer_irq), .evt_irq(evt_irq));
`default_nettype wire

// [pdt_pin_model.sv]
// pdt_pin_model: external timer pin source, toggles every four clocks while run
// assumes clk_sys; holds level while not running
`timescale 1ns/1ps
`default_nettype none
module pdt_pin_model (
  input wire logic clk_sys,
  input wire logic run,
  input wire logic level,
  output logic timer_pin,
  output logic [7:0] rises
);
  logic [1:0] ph;
  initial begin
    timer_pin = 1'b0;
    rises = 8'h00;
    ph = 2'h0;
  end
  always @(posedge clk_sys) begin
    if (run) begin
      ph <= ph + 2'h1;
      if (ph == 2'h3) begin
        timer_pin <= ~timer_pin;
        rises <= timer_pin ? rises : rises + 8'h01;
      end
    end else begin
      timer_pin <= level;
      ph <= 2'h0;
    end
  end
endmodule : pdt_pin_model
`default_nettype wire

// [pdt_timer_tb.sv]
// pdt_timer_tb: self-checking bench for pdt_timer over apb
// assumes pdt_pkg, pdt_pin_model and the bound checker are compiled first
`timescale 1ns/1ps
`default_nettype none
module pdt_timer_tb;
  import pdt_pkg::*;
  logic clk_sys, srst, psel, penable, pwrite, cpu_int_mask, pin_run, pin_lvl, last_err;
  logic pready, pslverr, timer_pin, timer_irq, evt_irq;
  logic [7:0] paddr, pin_rises;
  logic [31:0] pwdata, prdata, rd_val, v1;
  logic [3:0] pstrb;
  int error_cnt, check_count, n;
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  pdt_timer dut (.clk_sys(clk_sys), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .timer_pin(timer_pin),
    .cpu_int_mask(cpu_int_mask), .timer_irq(timer_irq), .evt_irq(evt_irq));
  pdt_pin_model u_pin (.clk_sys(clk_sys), .run(pin_run), .level(pin_lvl), .timer_pin(timer_pin), .rises(pin_rises));
  ////////////////////////////////////////
  task chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected at %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task tick(input int c);
    repeat (c) @(posedge clk_sys);
  endtask : tick
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk_sys);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) begin
      error_cnt++;
      $display("unexpected at %0t pready %h exp %h", $time, pready, 1'b1);
    end
    rd_val = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd_val, e);
  endtask : rd
  task test_done();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : test_done
  ////////////////////////////////////////
  task t_regs();
    // counter holds no reset value; load it before the first phase-two step decodes it
    apb(1'b1, PDT_ADDR_TDR, 32'hFF);
    rd(PDT_ADDR_TCR, 32'h40);
    rd(PDT_ADDR_EVT, 32'h0);
    rd(PDT_ADDR_EMSK, 32'h0);
    rd(8'hFC, 32'h0);
    chk(last_err, 32'h1);
    pstrb <= 4'h0;
    apb(1'b1, PDT_ADDR_TCR, 32'h00);
    pstrb <= 4'hF;
    apb(1'b1, PDT_ADDR_TCR, 32'h48);
    rd(PDT_ADDR_TCR, 32'h40);
    $display("t_regs done");
  endtask : t_regs
  task t_count();
    apb(1'b1, PDT_ADDR_EMSK, 32'h1);
    apb(1'b1, PDT_ADDR_TCR, 32'h0);
    apb(1'b1, PDT_ADDR_TDR, 32'h2);
    n = 0;
    while (timer_irq !== 1'b1 && n < 40) begin
      tick(1);
      n++;
    end
    chk(n <= 10, 32'h1);
    tick(2);
    chk(evt_irq, 32'h1);
    rd(PDT_ADDR_TCR, 32'h80);
    tick(8);
    rd(PDT_ADDR_EVT, 32'h3);
    rd(PDT_ADDR_EVT, 32'h0);
    tick(2);
    chk(evt_irq, 32'h0);
    rd(PDT_ADDR_TCR, 32'h80);
    cpu_int_mask <= 1'b1;
    tick(3);
    chk(timer_irq, 32'h0);
    cpu_int_mask <= 1'b0;
    tick(3);
    chk(timer_irq, 32'h1);
    apb(1'b1, PDT_ADDR_TCR, 32'hC0);
    tick(2);
    chk(timer_irq, 32'h0);
    apb(1'b1, PDT_ADDR_TCR, 32'h00);
    rd(PDT_ADDR_TCR, 32'h00);
    $display("t_count done");
  endtask : t_count
  task t_div();
    for (int s = 0; s < 8; s++) begin
      apb(1'b1, PDT_ADDR_TCR, 32'h20);
      apb(1'b1, PDT_ADDR_TDR, 32'h1);
      tick(12);
      rd(PDT_ADDR_TDR, 32'h1);
      apb(1'b1, PDT_ADDR_TCR, 32'h08 | s);
      n = 0;
      while (timer_irq !== 1'b1 && n < 600) begin
        tick(1);
        n++;
      end
      chk(n >= (4 << s) - 3 && n <= (4 << s) + 2, 32'h1);
    end
    $display("t_div done");
  endtask : t_div
  task t_pin();
    apb(1'b1, PDT_ADDR_TCR, 32'h70);
    apb(1'b1, PDT_ADDR_TDR, 32'h80);
    pin_run <= 1'b1;
    tick(81);
    pin_run <= 1'b0;
    tick(6);
    rd(PDT_ADDR_TDR, 32'h80 - pin_rises);
    apb(1'b1, PDT_ADDR_TCR, 32'h50);
    apb(1'b1, PDT_ADDR_TDR, 32'h80);
    pin_lvl <= 1'b1;
    tick(40);
    apb(1'b0, PDT_ADDR_TDR, 32'h0);
    chk(rd_val != 32'h80, 32'h1);
    pin_lvl <= 1'b0;
    tick(2);
    apb(1'b0, PDT_ADDR_TDR, 32'h0);
    v1 = rd_val;
    tick(40);
    rd(PDT_ADDR_TDR, v1);
    $display("t_pin done");
  endtask : t_pin
  task t_rst();
    apb(1'b1, PDT_ADDR_TCR, 32'h20);
    apb(1'b1, PDT_ADDR_TDR, 32'h55);
    srst <= 1'b1;
    tick(2);
    srst <= 1'b0;
    apb(1'b0, PDT_ADDR_TDR, 32'h0);
    chk(rd_val == 32'h55 || rd_val == 32'h54, 32'h1);
    rd(PDT_ADDR_TCR, 32'h40);
    $display("t_rst done");
  endtask : t_rst
  ////////////////////////////////////////
  initial begin
    srst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pstrb = 4'hF;
    cpu_int_mask = 1'b0;
    pin_run = 1'b0;
    pin_lvl = 1'b0;
    error_cnt = 0;
    check_count = 0;
    tick(4);
    srst <= 1'b0;
    t_regs();
    t_count();
    t_div();
    t_pin();
    t_rst();
    test_done();
  end
  initial begin
    tick(20000);
    error_cnt++;
    test_done();
  end
endmodule : pdt_timer_tb
`default_nettype wire
